// File: include/dfp_pkg.sv
// Shared constants for the feedback divider and phase configuration bank
package dfp_pkg;
    // AXI4-Lite geometry
    localparam int unsigned DFP_ADDR_W = 8;
    localparam logic [1:0] DFP_RESP_OKAY = 2'h0;
    localparam logic [1:0] DFP_RESP_SLVERR = 2'h2;

    // Byte addresses of the register words
    localparam logic [7:0] DFP_NUM_LO_OFS = 8'h00;
    localparam logic [7:0] DFP_NUM_HI_OFS = 8'h04;
    localparam logic [7:0] DFP_DEN_LO_OFS = 8'h08;
    localparam logic [7:0] DFP_DEN_HI_OFS = 8'h0C;
    localparam logic [7:0] DFP_INT_OFS = 8'h10;
    localparam logic [7:0] DFP_CORR_OFS = 8'h14;
    localparam logic [7:0] DFP_PHASE_OFS = 8'h18;
    localparam logic [7:0] DFP_ACTIVE_OFS = 8'h1C;

    // Field widths
    localparam int unsigned DFP_INT_W = 14;
    localparam int unsigned DFP_FRAC_W = 48;
    localparam int unsigned DFP_PHASE_W = 30;
    localparam int unsigned DFP_FINE_W = 31;
    localparam int unsigned DFP_MULT_W = 7;
    localparam int unsigned DFP_REM_W = 8;
    localparam int unsigned DFP_CORR_OUT_W = DFP_REM_W + DFP_MULT_W;

    // Correction config field positions
    localparam int unsigned DFP_FINE_REV_BIT = 9;
    localparam int unsigned DFP_PEC_DLY_HI = 8;
    localparam int unsigned DFP_PEC_DLY_LO = 7;
    localparam int unsigned DFP_MULT_HI = 6;
    localparam int unsigned DFP_CORR_W = 10;

    // Byte lanes that commit the staged atomic values
    localparam int unsigned DFP_FRAC_MSB_LANE = 1;
    localparam int unsigned DFP_PHASE_MSB_LANE = 3;

    // Correction delay code that inserts one cycle
    localparam logic [1:0] DFP_PEC_DLY_ONE = 2'h1;

    // Values after reset
    localparam logic [13:0] DFP_INT_RST = 14'h0190;
    localparam logic [47:0] DFP_NUM_RST = 48'h000000000000;
    localparam logic [47:0] DFP_DEN_RST = 48'h000000800000;
    localparam logic [9:0] DFP_CORR_RST = 10'h000;
    localparam logic [29:0] DFP_PHASE_RST = 30'h00000000;
endpackage

// File: design/dfp_fine_reorder.sv
// Fine timestamp line ordering from the time-to-digital converter
`timescale 1ns/1ps
`default_nettype none
module dfp_fine_reorder import dfp_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [DFP_FINE_W-1:0] fine_raw,
    input wire logic reverse,
    output logic [DFP_FINE_W-1:0] fine_word_ff
);
    logic [DFP_FINE_W-1:0] flipped;
    logic [DFP_FINE_W-1:0] nxt_fine_word;

    // Mirror of the raw lines, one wire per bit
    for (genvar i = 0; i < DFP_FINE_W; i++) begin : g_flip
        assign flipped[i] = fine_raw[DFP_FINE_W-1-i];
    end

    // Order select
    always_comb begin
        nxt_fine_word = reverse ? flipped : fine_raw;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fine_word_ff <= '0;
        end else begin
            fine_word_ff <= nxt_fine_word;
        end
    end

    fine_rev_a: assert property (@(posedge clk) disable iff (sys_rst)
        reverse |=> fine_word_ff[0] == $past(fine_raw[DFP_FINE_W-1]) &&
            fine_word_ff[DFP_FINE_W-1] == $past(fine_raw[0]))
        else $error("reversed fine word misordered");
    fine_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        !reverse |=> fine_word_ff == $past(fine_raw))
        else $error("natural fine word altered");
endmodule
`default_nettype wire

// File: design/dfp_pec_corr.sv
// Phase error correction: optional delay and scaling of the remainder
`timescale 1ns/1ps
`default_nettype none
module dfp_pec_corr import dfp_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [DFP_REM_W-1:0] sdm_remainder,
    input wire logic [1:0] pec_delay,
    input wire logic [DFP_MULT_W-1:0] corr_mult,
    output logic [DFP_CORR_OUT_W-1:0] corr_ff
);
    logic [DFP_REM_W-1:0] rem_d1_ff;
    logic [DFP_REM_W-1:0] nxt_rem_d1;
    logic [DFP_REM_W-1:0] rem_sel;
    logic [DFP_CORR_OUT_W-1:0] nxt_corr;

    // Delay select then scale to converter phase resolution
    always_comb begin
        nxt_rem_d1 = sdm_remainder;
        rem_sel = (pec_delay == DFP_PEC_DLY_ONE) ? rem_d1_ff : sdm_remainder;
        nxt_corr = DFP_CORR_OUT_W'(rem_sel) * DFP_CORR_OUT_W'(corr_mult);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rem_d1_ff <= '0;
            corr_ff <= '0;
        end else begin
            rem_d1_ff <= nxt_rem_d1;
            corr_ff <= nxt_corr;
        end
    end

    pec_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pec_delay == 2'h1) ##1 1'b1 |-> corr_ff ==
            DFP_CORR_OUT_W'($past(sdm_remainder, 2)) *
            DFP_CORR_OUT_W'($past(corr_mult)))
        else $error("one cycle correction delay wrong");
    pec_nodelay_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pec_delay != 2'h1) |=> corr_ff ==
            DFP_CORR_OUT_W'($past(sdm_remainder)) *
            DFP_CORR_OUT_W'($past(corr_mult)))
        else $error("undelayed correction wrong");
endmodule
`default_nettype wire

// File: design/dfp_feedback_regs.sv
// Feedback divider, correction and phase offset register bank over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module dfp_feedback_regs import dfp_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [DFP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [DFP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic hitless_switch_en,
    input wire logic [DFP_FINE_W-1:0] fine_raw_in,
    input wire logic [DFP_REM_W-1:0] sdm_remainder,
    output logic [DFP_INT_W-1:0] loop_fb_int_ff,
    output logic [DFP_FRAC_W-1:0] loop_fb_num_ff,
    output logic [DFP_FRAC_W-1:0] loop_fb_den_ff,
    output logic loop_fb_apply_ff,
    output logic [DFP_PHASE_W-1:0] loop_phase_offset_ff,
    output logic [DFP_FINE_W-1:0] fine_word_ff,
    output logic [DFP_CORR_OUT_W-1:0] pec_corr_ff
);
    // Bus channel state
    logic aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
    logic [DFP_ADDR_W-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid, wr_fire, wr_hit;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    // Register state
    logic [DFP_FRAC_W-1:0] num_sh_ff, nxt_num_sh, den_sh_ff, nxt_den_sh;
    logic [DFP_INT_W-1:0] int_ff, nxt_int;
    logic [DFP_CORR_W-1:0] corr_ff, nxt_corr;
    logic [DFP_PHASE_W-1:0] phase_sh_ff, nxt_phase_sh;
    logic [DFP_PHASE_W-1:0] phase_act_ff, nxt_phase_act, nxt_phase_out;
    logic [DFP_INT_W-1:0] nxt_loop_int;
    logic [DFP_FRAC_W-1:0] nxt_loop_num, nxt_loop_den;
    logic nxt_apply, int_trig, num_trig, den_trig, phase_trig, grp_trig;
    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction
    // Address decode
    function automatic logic addr_hit(input logic [DFP_ADDR_W-1:0] a);
        return a == DFP_NUM_LO_OFS || a == DFP_NUM_HI_OFS ||
            a == DFP_DEN_LO_OFS || a == DFP_DEN_HI_OFS ||
            a == DFP_INT_OFS || a == DFP_CORR_OFS ||
            a == DFP_PHASE_OFS || a == DFP_ACTIVE_OFS;
    endfunction
    assign wr_fire = aw_full_ff && w_full_ff && !bvalid_ff;
    assign wr_hit = addr_hit(awaddr_ff);
    // Write address, data and response channels
    always_comb begin
        nxt_aw_full = aw_full_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_full = w_full_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_full = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_full = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) nxt_bvalid = 1'b0;
        if (wr_fire) begin
            nxt_aw_full = 1'b0;
            nxt_w_full = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_hit ? DFP_RESP_OKAY : DFP_RESP_SLVERR;
        end
        nxt_awready = !nxt_aw_full && !nxt_bvalid;
        nxt_wready = !nxt_w_full && !nxt_bvalid;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_full_ff <= 1'b0;
            awaddr_ff <= '0;
            w_full_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= DFP_RESP_OKAY;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end else begin
            aw_full_ff <= nxt_aw_full;
            awaddr_ff <= nxt_awaddr;
            w_full_ff <= nxt_w_full;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
        end
    end
    // Register writes, staging and atomic commits
    always_comb begin
        logic [31:0] m;
        m = lane_merge(32'h00000000, wdata_ff, wstrb_ff);
        nxt_num_sh = num_sh_ff;
        nxt_den_sh = den_sh_ff;
        nxt_int = int_ff;
        nxt_corr = corr_ff;
        nxt_phase_sh = phase_sh_ff;
        int_trig = 1'b0;
        num_trig = 1'b0;
        den_trig = 1'b0;
        phase_trig = 1'b0;
        if (wr_fire) begin
            unique case (awaddr_ff)
                DFP_NUM_LO_OFS: nxt_num_sh[31:0] = lane_merge(num_sh_ff[31:0],
                    wdata_ff, wstrb_ff);
                DFP_NUM_HI_OFS: begin
                    m = lane_merge({16'h0000, num_sh_ff[47:32]}, wdata_ff,
                        wstrb_ff);
                    nxt_num_sh[47:32] = m[15:0];
                    num_trig = wstrb_ff[DFP_FRAC_MSB_LANE];
                end
                DFP_DEN_LO_OFS: nxt_den_sh[31:0] = lane_merge(den_sh_ff[31:0],
                    wdata_ff, wstrb_ff);
                DFP_DEN_HI_OFS: begin
                    m = lane_merge({16'h0000, den_sh_ff[47:32]}, wdata_ff,
                        wstrb_ff);
                    nxt_den_sh[47:32] = m[15:0];
                    den_trig = wstrb_ff[DFP_FRAC_MSB_LANE];
                end
                DFP_INT_OFS: begin
                    m = lane_merge({18'h00000, int_ff}, wdata_ff, wstrb_ff);
                    nxt_int = m[DFP_INT_W-1:0];
                    int_trig = (m[DFP_INT_W-1:0] != int_ff);
                end
                DFP_CORR_OFS: begin
                    m = lane_merge({22'h000000, corr_ff}, wdata_ff, wstrb_ff);
                    nxt_corr = m[DFP_CORR_W-1:0];
                end
                DFP_PHASE_OFS: begin
                    m = lane_merge({2'h0, phase_sh_ff}, wdata_ff, wstrb_ff);
                    nxt_phase_sh = m[DFP_PHASE_W-1:0];
                    phase_trig = wstrb_ff[DFP_PHASE_MSB_LANE];
                end
                default: ;
            endcase
        end
    end
    assign grp_trig = int_trig || num_trig || den_trig;
    // Loop-side values: change on a commit; the phase offset output also follows hitless_switch_en
    always_comb begin
        nxt_loop_int = loop_fb_int_ff;
        nxt_loop_num = loop_fb_num_ff;
        nxt_loop_den = loop_fb_den_ff;
        nxt_phase_act = phase_act_ff;
        nxt_apply = grp_trig;
        if (grp_trig) begin
            nxt_loop_int = nxt_int;
            nxt_loop_num = nxt_num_sh;
            nxt_loop_den = nxt_den_sh;
        end
        if (phase_trig) nxt_phase_act = nxt_phase_sh;
        // Single offset shared by all outputs, dropped under hitless switching
        nxt_phase_out = hitless_switch_en ? '0 : phase_act_ff;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            num_sh_ff <= DFP_NUM_RST;
            den_sh_ff <= DFP_DEN_RST;
            int_ff <= DFP_INT_RST;
            corr_ff <= DFP_CORR_RST;
            phase_sh_ff <= DFP_PHASE_RST;
            phase_act_ff <= DFP_PHASE_RST;
            loop_fb_int_ff <= DFP_INT_RST;
            loop_fb_num_ff <= DFP_NUM_RST;
            loop_fb_den_ff <= DFP_DEN_RST;
            loop_fb_apply_ff <= 1'b0;
            loop_phase_offset_ff <= DFP_PHASE_RST;
        end else begin
            num_sh_ff <= nxt_num_sh;
            den_sh_ff <= nxt_den_sh;
            int_ff <= nxt_int;
            corr_ff <= nxt_corr;
            phase_sh_ff <= nxt_phase_sh;
            phase_act_ff <= nxt_phase_act;
            loop_fb_int_ff <= nxt_loop_int;
            loop_fb_num_ff <= nxt_loop_num;
            loop_fb_den_ff <= nxt_loop_den;
            loop_fb_apply_ff <= nxt_apply;
            loop_phase_offset_ff <= nxt_phase_out;
        end
    end
    // Read channel; reserved bits read zero
    always_comb begin
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
        if (s_axi_arvalid && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = addr_hit(s_axi_araddr) ? DFP_RESP_OKAY :
                DFP_RESP_SLVERR;
            unique case (s_axi_araddr)
                DFP_NUM_LO_OFS: nxt_rdata = num_sh_ff[31:0];
                DFP_NUM_HI_OFS: nxt_rdata = {16'h0000, num_sh_ff[47:32]};
                DFP_DEN_LO_OFS: nxt_rdata = den_sh_ff[31:0];
                DFP_DEN_HI_OFS: nxt_rdata = {16'h0000, den_sh_ff[47:32]};
                DFP_INT_OFS: nxt_rdata = {18'h00000, int_ff};
                DFP_CORR_OFS: nxt_rdata = {22'h000000, corr_ff};
                DFP_PHASE_OFS: nxt_rdata = {2'h0, phase_sh_ff};
                DFP_ACTIVE_OFS: nxt_rdata = {hitless_switch_en, 17'h00000,
                    loop_fb_int_ff};
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= DFP_RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    // Fine line ordering
    dfp_fine_reorder u_fine (
        .clk(clk),
        .sys_rst(sys_rst),
        .fine_raw(fine_raw_in),
        .reverse(corr_ff[DFP_FINE_REV_BIT]),
        .fine_word_ff(fine_word_ff)
    );
    // Sigma-delta remainder correction
    dfp_pec_corr u_pec (
        .clk(clk),
        .sys_rst(sys_rst),
        .sdm_remainder(sdm_remainder),
        .pec_delay(corr_ff[DFP_PEC_DLY_HI:DFP_PEC_DLY_LO]),
        .corr_mult(corr_ff[DFP_MULT_HI:0]),
        .corr_ff(pec_corr_ff)
    );
    int_readback_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_axi_arvalid && arready_ff && s_axi_araddr == DFP_INT_OFS |=>
            rvalid_ff && rdata_ff[31:14] == 18'h00000 &&
            rdata_ff[13:0] == $past(int_ff))
        else $error("integer divisor readback wrong");
    int_apply_a: assert property (@(posedge clk) disable iff (sys_rst)
        int_trig |=> loop_fb_apply_ff && loop_fb_int_ff == int_ff &&
            loop_fb_num_ff == num_sh_ff && loop_fb_den_ff == den_sh_ff)
        else $error("integer change did not apply group");
    frac_apply_a: assert property (@(posedge clk) disable iff (sys_rst)
        (num_trig || den_trig) |=> loop_fb_apply_ff &&
            loop_fb_num_ff == num_sh_ff && loop_fb_den_ff == den_sh_ff &&
            loop_fb_int_ff == int_ff)
        else $error("fraction top byte did not apply group");
    group_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !grp_trig |=> !loop_fb_apply_ff && $stable(loop_fb_num_ff) &&
            $stable(loop_fb_den_ff) && $stable(loop_fb_int_ff))
        else $error("loop divider moved without commit");
    phase_commit_a: assert property (@(posedge clk) disable iff (sys_rst)
        phase_trig |=> phase_act_ff == phase_sh_ff)
        else $error("phase top byte did not commit");
    phase_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !phase_trig |=> $stable(phase_act_ff))
        else $error("phase offset moved without commit");
    hitless_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        hitless_switch_en |=> loop_phase_offset_ff == '0)
        else $error("phase offset used under hitless switching");
    phase_out_a: assert property (@(posedge clk) disable iff (sys_rst)
        !hitless_switch_en |=> loop_phase_offset_ff == $past(phase_act_ff))
        else $error("applied phase offset mismatch");
    write_resp_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_fire |=> bvalid_ff && !awready_ff && !wready_ff)
        else $error("write response missing");
endmodule
`default_nettype wire

// File: tb/dfp_host.sv
// Host software model: AXI4-Lite master driving the register bank
`timescale 1ns/1ps
`default_nettype none
module dfp_host import dfp_pkg::*; (
    input wire logic clk,
    output logic [DFP_ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [DFP_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Idle bus at time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
        s_axi_wstrb = 4'h0;
    end
    // One write; released address and data lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    // One read; rready stays up until the answer is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the feedback register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top import dfp_pkg::*; ;
    logic clk, sys_rst, hitless_switch_en, s_axi_awvalid, s_axi_awready;
    logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, sdm_remainder, p1, p2;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rdat, mw [8];
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [30:0] fine_raw_in, fine_word_ff, f1, fr;
    logic [13:0] loop_fb_int_ff, a_int;
    logic [47:0] loop_fb_num_ff, loop_fb_den_ff, a_num, a_den;
    logic [29:0] loop_phase_offset_ff, a_ph;
    logic [14:0] pec_corr_ff;
    logic loop_fb_apply_ff;
    int failures, comparisons, applies, x_ap;
    // Writable bits of each word
    localparam logic [31:0] msk [8] = '{32'hFFFFFFFF, 32'h0000FFFF,
        32'hFFFFFFFF, 32'h0000FFFF, 32'h00003FFF, 32'h000003FF,
        32'h3FFFFFFF, 32'h0};
    dfp_host i_dfp_host(.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    dfp_feedback_regs i_dfp_feedback_regs(.clk, .sys_rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .hitless_switch_en, .fine_raw_in, .sdm_remainder, .loop_fb_int_ff,
        .loop_fb_num_ff, .loop_fb_den_ff, .loop_fb_apply_ff,
        .loop_phase_offset_ff, .fine_word_ff, .pec_corr_ff);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Apply pulses seen on the loop side
    always @(posedge clk) begin
        if (loop_fb_apply_ff === 1'b1) applies <= applies + 1;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        report_and_stop;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string n, input logic [47:0] e, logic [47:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Model applies divisor group to the loop
    task automatic commit;
        {a_num, a_den} = {mw[1][15:0], mw[0], mw[3][15:0], mw[2]};
        a_int = mw[4][13:0];
        x_ap++;
    endtask
    task automatic chk_loop;
        chk("int", a_int, loop_fb_int_ff);
        chk("num", a_num, loop_fb_num_ff);
        chk("den", a_den, loop_fb_den_ff);
        chk("apply", 48'(x_ap), 48'(applies));
        chk("phase", hitless_switch_en ? 30'h0 : a_ph,
            loop_phase_offset_ff);
    endtask
    task automatic wreg(input logic [7:0] a, logic [31:0] d, logic [3:0] s);
        logic [31:0] o, m;
        logic [2:0] i;
        i = a[4:2];
        o = mw[i];
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & msk[i];
        i_dfp_host.wr(a, d, s, resp);
        chk("bresp", a > 8'h1C ? 2'h2 : 2'h0, resp);
        if (a <= 8'h1C) begin
            mw[i] = (o & ~m) | (d & m);
            if (((i == 1 || i == 3) && s[1]) || (i == 4 && mw[4] != o)) commit;
            if (i == 6 && s[3]) a_ph = mw[6][29:0];
        end
        @(negedge clk);
        chk_loop;
    endtask
    task automatic rreg(input logic [7:0] a);
        logic [31:0] e;
        e = a > 8'h1C ? 32'h0 : mw[a[4:2]];
        if (a == 8'h1C) e = {hitless_switch_en, 17'h0, a_int};
        i_dfp_host.rd(a, rdat, resp);
        chk("rdata", e, rdat);
        chk("rresp", a > 8'h1C ? 2'h2 : 2'h0, resp);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Reset, then scenarios in order
    initial begin
        sys_rst = 1'b1;
        {hitless_switch_en, fine_raw_in, sdm_remainder} = 40'h0;
        seed = 32'hDC0046DF;
        mw = '{0, 0, 32'h00800000, 0, 32'h00000190, 0, 0, 0};
        a_ph = 30'h0;
        commit;
        x_ap = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk_loop;
        for (int i = 0; i < 10; i++) rreg(8'(4 * i));
        $display("test reset done");
        wreg(8'h10, 32'hFFFFFFFF, 4'hF);
        rreg(8'h10);
        wreg(8'h10, 32'hFFFFFFFF, 4'hF);
        wreg(8'h10, 32'h00000190, 4'h1);
        $display("test divisor done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wreg(8'(4 * i), seed, i[0] ? 4'h1 : 4'hF);
            rreg(8'(4 * i));
        end
        wreg(8'h04, seed, 4'h2);
        wreg(8'h0C, 32'h00008000, 4'h2);
        wreg(8'h20, seed, 4'hF);
        wreg(8'h1C, seed, 4'hF);
        $display("test fraction done");
        wreg(8'h18, seed, 4'h7);
        wreg(8'h18, ~seed, 4'h8);
        rreg(8'h18);
        @(posedge clk);
        hitless_switch_en <= 1'b1;
        repeat (2) @(negedge clk);
        chk_loop;
        rreg(8'h1C);
        hitless_switch_en <= 1'b0;
        $display("test phase done");
        for (int c = 0; c < 8; c++) begin
            seed = lfsr(seed);
            wreg(8'h14, {22'h0, c[2:0], seed[6:0]}, 4'h3);
            rreg(8'h14);
            for (int k = 0; k < 6; k++) begin
                @(posedge clk);
                seed = lfsr(seed);
                p2 = p1;
                p1 = sdm_remainder;
                f1 = fine_raw_in;
                fr = {<<{fine_raw_in}};
                sdm_remainder <= seed[7:0];
                fine_raw_in <= seed[31:1];
                @(negedge clk);
                if (k > 1) begin
                    chk("fine", c[2] ? fr : f1, fine_word_ff);
                    chk("corr", mw[5][6:0] * (c[1:0] == 1 ? p2 : p1),
                        pec_corr_ff);
                end
            end
        end
        $display("test correction done");
        report_and_stop;
    end
endmodule
`default_nettype wire
